// [ebw_pkg.sv]
// Package for the external area wait timing block: register map, field layout,
// reset values, state encoding and the packed state record.
// Assumes a 32-bit APB register bus and one external asynchronous memory area.
package ebw_pkg;

  // Register map and layout of the area access wait control register.
  localparam logic [11:0] EBW_CTRL_OFS    = 12'h000;
  localparam int          EBW_WAIT_LSB    = 7;
  localparam int          EBW_MASK_BIT    = 6;
  localparam int          EBW_HOLD_LSB    = 0;
  localparam logic [3:0]  EBW_WAIT_RST    = 4'ha;
  localparam logic        EBW_MASK_RST    = 1'h0;
  localparam logic [1:0]  EBW_HOLD_RST    = 2'h0;
  localparam logic [31:0] EBW_CTRL_WMASK  = 32'h0000_07c3;

  // External bus widths.
  localparam int EBW_AW = 24;
  localparam int EBW_DW = 16;

  // One external bus cycle spans this many clk cycles, so half a bus cycle is one clk.
  localparam logic [5:0] EBW_CLK_PER_BUS = 6'h02;

  // Access sequencer states, Gray coded along idle, strobe, wait, hold.
  typedef enum logic [1:0] {
    EBW_IDLE   = 2'b00,
    EBW_STROBE = 2'b01,
    EBW_WAITX  = 2'b11,
    EBW_HOLD   = 2'b10
  } ebw_state_t;

  // Whole state of the block.
  typedef struct packed {
    ebw_state_t              st;
    logic [5:0]              cnt;
    logic [3:0]              cfgWait;
    logic                    cfgMask;
    logic [1:0]              cfgHold;
    logic                    isWrite;
    logic [EBW_AW-1:0]       addr;
    logic [EBW_DW-1:0]       wdata;
    logic [EBW_DW-1:0]       rdata;
    logic                    done;
    logic                    waitS1;
    logic                    waitS2;
    logic [EBW_DW-1:0]       dinS1;
    logic [EBW_DW-1:0]       dinS2;
    logic                    chip_select_n;
    logic                    rdn;
    logic                    wrn;
    logic                    oen;
    logic [31:0]             prdata;
    logic                    pslverr;
  } ebw_regs_t;

endpackage

// [ebw_ext_wait_timing.sv]
// Top of the external area wait timing block: APB control register and the
// access sequencer that drives address, chip select and strobes of one area.
// Assumes clk runs at twice the external bus clock and that the wait and data
// pins are asynchronous to clk.
//
// How it works
// - Read wait code 0-6 gives 0-6 cycles, then 8,10,12,14,18,24 cycles.
// - Mask bit 0 obeys the external wait input; mask bit 1 ignores it.
// - The mask applies even with zero programmed wait cycles.
// - Reserved bits 5 to 2 read as zero; software writes zero.
// - Address and select stay 0.5 to 3.5 cycles after strobe negation.
// - Reset gives wait code 1010, mask 0 and hold field 0.
`timescale 1ns/100ps
module ebw_ext_wait_timing
(
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      accReq,
  input  wire logic                      accWrite,
  input  wire logic [ebw_pkg::EBW_AW-1:0] accAddr,
  input  wire logic [ebw_pkg::EBW_DW-1:0] accWdata,
  output logic                           accReady,
  output logic                           accDone,
  output logic      [ebw_pkg::EBW_DW-1:0] accRdata,
  output logic      [ebw_pkg::EBW_AW-1:0] extAddr,
  output logic                           chipSelectN,
  output logic                           readStrobeN,
  output logic                           storeStrobeN,
  output logic      [ebw_pkg::EBW_DW-1:0] extDataOut,
  output logic                           extDataOeN,
  input  wire logic [ebw_pkg::EBW_DW-1:0] extDataIn,
  input  wire logic                      extWait
);
  import ebw_pkg::*;

  ebw_regs_t r;
  ebw_regs_t next_r;

  // Maps a read wait code to bus cycles; reserved codes behave as the longest.
  function automatic logic [4:0] waitCycles(input logic [3:0] code);
    case (code)
      4'h7:    waitCycles = 5'h08;
      4'h8:    waitCycles = 5'h0a;
      4'h9:    waitCycles = 5'h0c;
      4'ha:    waitCycles = 5'h0e;
      4'hb:    waitCycles = 5'h12;
      4'hc:    waitCycles = 5'h18;
      default: waitCycles = (code > 4'hc) ? 5'h18 : {1'b0, code};
    endcase
  endfunction

  // Length of the strobe phase in clk cycles minus one: base bus cycle, plus waits on reads only.
  function automatic logic [5:0] strobeCount(input logic wr, input logic [3:0] code);
    logic [5:0] cyc;
    cyc = wr ? 6'h01 : 6'({1'b0, waitCycles(code)} + 6'h01);
    strobeCount = 6'(cyc * EBW_CLK_PER_BUS - 6'h01);
  endfunction

  // Only the control register is mapped; any other offset answers with an error.
  wire logic ctrlHit = (paddr == EBW_CTRL_OFS);

  // Next-state logic: register bus, synchronisers and access sequencer.
  always_comb
  begin
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.waitS1 = extWait;
    next_r.waitS2 = r.waitS1;
    next_r.dinS1  = extDataIn;
    next_r.dinS2  = r.dinS1;
    // Setup phase prepares read data and the error answer for the access phase.
    if (psel && !penable)
    begin
      next_r.pslverr = !ctrlHit;
      next_r.prdata  = '0;
      if (ctrlHit && !pwrite)
        next_r.prdata = {21'h0, r.cfgWait, r.cfgMask, 4'h0, r.cfgHold};
    end
    if (psel && penable && pwrite && ctrlHit)
    begin
      next_r.cfgWait = pwdata[EBW_WAIT_LSB +: 4];
      next_r.cfgMask = pwdata[EBW_MASK_BIT];
      next_r.cfgHold = pwdata[EBW_HOLD_LSB +: 2];
    end
    case (r.st)
      EBW_IDLE:
      begin
        if (accReq)
        begin
          next_r.st      = EBW_STROBE;
          next_r.isWrite = accWrite;
          next_r.addr    = accAddr;
          next_r.wdata   = accWdata;
          next_r.cnt     = strobeCount(accWrite, r.cfgWait);
          next_r.chip_select_n     = 1'b0;
          next_r.rdn     = accWrite;
          next_r.wrn     = !accWrite;
          next_r.oen     = !accWrite;
        end
      end
      EBW_STROBE:
      begin
        // The wait pin is not looked at until the programmed cycles are spent.
        next_r.cnt = r.cnt - 6'h01;
        if (r.cnt == 6'h00)
          next_r.st = EBW_WAITX;
      end
      EBW_WAITX:
      begin
        // Stretch while the pin is asserted and not masked, even for zero waits.
        if (!(r.waitS2 && !r.cfgMask))
        begin
          next_r.st  = EBW_HOLD;
          next_r.rdn = 1'b1;
          next_r.wrn = 1'b1;
          next_r.cnt = 6'({r.cfgHold, 1'b0});
          if (!r.isWrite)
            next_r.rdata = r.dinS2;
        end
      end
      EBW_HOLD:
      begin
        // Address and select stay for 2*hold+1 half bus cycles after strobe rise.
        next_r.cnt = r.cnt - 6'h01;
        if (r.cnt == 6'h00)
        begin
          next_r.st   = EBW_IDLE;
          next_r.chip_select_n  = 1'b1;
          next_r.oen  = 1'b1;
          next_r.done = 1'b1;
        end
      end
      default:
        next_r.st = EBW_IDLE;
    endcase
  end

  // State register with documented reset values.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r         <= '0;
      r.st      <= EBW_IDLE;
      r.cfgWait <= EBW_WAIT_RST;
      r.cfgMask <= EBW_MASK_RST;
      r.cfgHold <= EBW_HOLD_RST;
      r.chip_select_n     <= 1'b1;
      r.rdn     <= 1'b1;
      r.wrn     <= 1'b1;
      r.oen     <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Outputs.
  assign prdata       = r.prdata;
  assign pready       = 1'b1;
  assign pslverr      = r.pslverr;
  assign accReady     = (r.st == EBW_IDLE);
  assign accDone      = r.done;
  assign accRdata     = r.rdata;
  assign extAddr      = r.addr;
  assign chipSelectN  = r.chip_select_n;
  assign readStrobeN  = r.rdn;
  assign storeStrobeN = r.wrn;
  assign extDataOut   = r.wdata;
  assign extDataOeN   = r.oen;

  // Helper: clk cycles the read strobe has been low.
  logic [6:0] strobeLen;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      strobeLen <= '0;
    else if (r.rdn)
      strobeLen <= '0;
    else
      strobeLen <= strobeLen + 7'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  readWaitLen_a: assert property ($rose(r.rdn) |->
    strobeLen >= 7'(({1'b0, waitCycles(r.cfgWait)} + 6'h01) * EBW_CLK_PER_BUS))
    else $error("Read strobe shorter than the programmed wait.");
  maskIgnore_a: assert property (r.st == EBW_WAITX && r.cfgMask |=> r.st == EBW_HOLD)
    else $error("Masked wait input still stretched the access.");
  waitObey_a: assert property (r.st == EBW_WAITX && !r.cfgMask && r.waitS2 |=>
    r.st == EBW_WAITX && !chipSelectN)
    else $error("Unmasked wait input did not stretch the access.");
  zeroWait_a: assert property (r.st == EBW_WAITX && r.cfgWait == 4'h0 && !r.cfgMask
    && r.waitS2 && !r.isWrite |=> !readStrobeN)
    else $error("Zero-wait access not stretched by wait input.");
  reservedZero_a: assert property (psel && penable && !pwrite |-> prdata[5:2] == 4'h0)
    else $error("Reserved bits read as nonzero.");
  holdShort_a: assert property ($rose(readStrobeN) && r.cfgHold == 2'h0 |->
    !chipSelectN ##1 chipSelectN)
    else $error("Hold of half a cycle not met.");
  holdLong_a: assert property ($rose(storeStrobeN) && r.cfgHold == 2'h3 |->
    !chipSelectN [*7] ##1 chipSelectN)
    else $error("Hold of three and a half cycles not met.");
  resetVal_a: assert property (@(posedge clk) disable iff (1'b0)
    !$past(resetn) && resetn |-> r.cfgWait == 4'ha && !r.cfgMask && r.cfgHold == 2'h0)
    else $error("Control register reset value wrong.");
  noEarlyWait_a: assert property (r.st == EBW_STROBE && r.cnt != 6'h00 |=>
    r.st == EBW_STROBE)
    else $error("Wait phase entered before programmed cycles elapsed.");

  readCov_c: cover property (r.st == EBW_WAITX && !r.isWrite ##1 r.st == EBW_HOLD);
  stretchCov_c: cover property (r.st == EBW_WAITX [*3]);
  writeCov_c: cover property ($rose(storeStrobeN) && r.cfgHold == 2'h3);
  cfgWriteCov_c: cover property (psel && penable && pwrite && ctrlHit);
endmodule // ebw_ext_wait_timing

// [ebw_mem_model.sv]
// Model of the external memory that sits on one area of the block.
// Assumes active-low select and strobes, all on the one clk.
`timescale 1ns/100ps
module ebw_mem_model
(
  input  wire logic                      clk,
  input  wire logic [ebw_pkg::EBW_AW-1:0] extAddr,
  input  wire logic                      chipSelectN,
  input  wire logic                      readStrobeN,
  input  wire logic                      storeStrobeN,
  input  wire logic [ebw_pkg::EBW_DW-1:0] extDataOut,
  input  wire logic                      extDataOeN,
  input  wire logic [5:0]                waitLen,
  output logic      [ebw_pkg::EBW_DW-1:0] extDataIn,
  output logic                           extWait
);
  import ebw_pkg::*;
  logic [EBW_DW-1:0] mem [16];
  logic [EBW_DW-1:0] junk = 16'h5a5a;
  logic [5:0]        selCnt = 6'h00;
  // Stores on the write strobe and counts selected cycles for the wait pin.
  always_ff @(posedge clk)
  begin
    junk <= ~junk;
    selCnt <= chipSelectN ? 6'h00 : selCnt + 6'h01;
    if (!chipSelectN && !storeStrobeN && !extDataOeN)
      mem[extAddr[3:0]] <= extDataOut;
  end
  // Data only while selected and read; a released bus toggles every cycle.
  assign extDataIn = (!chipSelectN && !readStrobeN) ? mem[extAddr[3:0]] : junk;
  assign extWait   = !chipSelectN && (selCnt < waitLen);
endmodule // ebw_mem_model

// [ebw_ext_wait_timing_tb.sv]
// Self-checking bench for the external area wait timing block.
// Assumes the package and the memory model are compiled before it.
`timescale 1ns/100ps
module ebw_ext_wait_timing_tb;
  import ebw_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic accReq = 0, accWrite = 0, pready, pslverr, accReady, accDone;
  logic chipSelectN, readStrobeN, storeStrobeN, extDataOeN, extWait, errSeen;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rdVal;
  logic [EBW_AW-1:0] accAddr = '0, extAddr;
  logic [EBW_DW-1:0] accWdata = '0, accRdata, extDataOut, extDataIn;
  logic [5:0]        waitLen = '0;
  int errors = 0, tests_run = 0, nCyc, nHold, v;
  // Decoded read waits, one row per code.
  int waitRows [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

  ebw_ext_wait_timing ebw_ext_wait_timing_inst (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .accReq, .accWrite,
    .accAddr, .accWdata, .accReady, .accDone, .accRdata, .extAddr, .chipSelectN,
    .readStrobeN, .storeStrobeN, .extDataOut, .extDataOeN, .extDataIn, .extWait);
  ebw_mem_model ebw_mem_model_inst (.clk, .extAddr, .chipSelectN, .readStrobeN,
    .storeStrobeN, .extDataOut, .extDataOeN, .waitLen, .extDataIn, .extWait);

  // Free-running clock.
  initial forever #4 clk = ~clk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdVal = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One external access; counts cycles to done and select-only hold cycles.
  task automatic acc(logic wr, logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    accReq <= 1'b1;
    accWrite <= wr;
    accAddr <= {20'h0, a};
    accWdata <= d;
    @(posedge clk);
    while (accReady !== 1'b1) @(posedge clk);
    accReq <= 1'b0;
    nCyc = 0;
    nHold = 0;
    do
    begin
      @(posedge clk);
      #1;
      nCyc++;
      nHold += int'(!chipSelectN && readStrobeN && storeStrobeN);
    end
    while (accDone !== 1'b1 && nCyc < 200);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #100us;
    errors++;
    final_report();
  end

  // Main sequence: reset, code table, then wait-pin and reset cases.
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("idle pins", {25'h0, pready, accReady, accDone, chipSelectN, readStrobeN,
      storeStrobeN, extDataOeN}, 32'h0000_006f);
    apb(1'b0, EBW_CTRL_OFS, 32'h0);
    check("ctrl reset", rdVal, 32'h0000_0500);
    apb(1'b0, 12'h004, 32'h0);
    check("unmapped err", {31'h0, errSeen}, 32'h1);
    waitLen <= 6'h28;
    for (int c = 0; c < 13; c++)
    begin
      v = {21'h0, c[3:0], 1'b1, 4'h0, c[1:0]};
      apb(1'b1, EBW_CTRL_OFS, v);
      apb(1'b0, EBW_CTRL_OFS, 32'h0);
      check("ctrl", rdVal, v);
      acc(1'b1, c[3:0], 16'ha5c0 + c[15:0]);
      check("wr cycles", nCyc, 2 * c[1:0] + 4);
      check("wr hold", nHold, 2 * c[1:0] + 1);
      acc(1'b0, c[3:0], 16'h0);
      check("rd cycles", nCyc, 2 * waitRows[c] + 2 * c[1:0] + 4);
      check("rd hold", nHold, 2 * c[1:0] + 1);
      check("rd data", accRdata, 16'ha5c0 + c[15:0]);
    end
    apb(1'b1, EBW_CTRL_OFS, 32'h0000_0000);
    waitLen <= 6'h0c;
    acc(1'b0, 4'h1, 16'h0);
    check("zero wait stretch", nCyc >= 13 && nCyc <= 20, 1);
    apb(1'b1, EBW_CTRL_OFS, 32'h0000_0100);
    waitLen <= 6'h02;
    acc(1'b0, 4'h2, 16'h0);
    check("early wait ignored", nCyc, 8);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, EBW_CTRL_OFS, 32'h0);
    check("ctrl rereset", rdVal, 32'h0000_0500);
    final_report();
  end
endmodule // ebw_ext_wait_timing_tb
